// ---- pin_mux_pkg.sv ----
// Constants and carrier types for the encoder connector pin multiplexer
`default_nettype none
package pin_mux_pkg;

	// Channels served by one feedback board
	localparam int NUM_CH = 2;

	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Byte offsets; channel j sits one word above channel j-1
	localparam logic [3:0] CTRL_BASE = 4'h0;
	localparam logic [3:0] STAT_BASE = 4'h8;
	localparam int         CH_SEL_BIT = 2;
	localparam int         BANK_BIT   = 3;

	// Control word fields
	localparam int ROUTE_BIT  = 0;
	localparam int SERIAL_BIT = 1;
	localparam int DEC_LSB    = 4;
	localparam int DEC_W      = 3;

	// Status word fields
	localparam int ST_QUAD_BIT   = 0;
	localparam int ST_STROBE_BIT = 1;
	localparam int ST_AMP_BIT    = 2;
	localparam int ST_FAULT_BIT  = 3;
	localparam int ST_PINS_LSB   = 8;

	// Decode selections: phase A/B as pulse and direction, or quadrature
	localparam logic [DEC_W-1:0] DEC_PULSE_LO = 3'h0;
	localparam logic [DEC_W-1:0] DEC_PULSE_HI = 3'h4;
	localparam logic [DEC_W-1:0] DEC_QUAD_LO  = 3'h3;
	localparam logic [DEC_W-1:0] DEC_QUAD_HI  = 3'h7;

	// Power-on values
	localparam logic             ROUTE_RESET  = 1'b0;
	localparam logic             SERIAL_RESET = 1'b0;
	localparam logic [DEC_W-1:0] DEC_RESET    = DEC_QUAD_LO;

	// One bit per connector line (a, b, c are pairs; t, u, v, w single lines)
	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic t;
		logic u;
		logic v;
		logic w;
	} pin_bits_t;

	// Board jumpers per channel
	typedef struct packed {
		logic amp_en;
		logic fault_en;
		logic strobe_off;
	} jumper_t;

	// Signals the axis logic drives toward the connector
	typedef struct packed {
		logic amp_enable;
		logic step_pulse;
		logic step_dir;
		logic ser_clk;
		logic ser_strobe;
		logic ser_data;
		logic ser_data_oe;
	} axis_drive_t;

	// Signals handed back to the axis logic
	typedef struct packed {
		logic quad_a;
		logic quad_b;
		logic pulse_in;
		logic dir_in;
		logic quad_mode;
		logic fault;
		logic capture;
		logic gp_flag;
		logic hall_u;
		logic hall_v;
		logic hall_w;
		logic ser_data_in;
	} axis_sense_t;

	// Software settings of one channel
	typedef struct packed {
		logic             route;
		logic             serial;
		logic [DEC_W-1:0] decode;
	} chan_cfg_t;

endpackage : pin_mux_pkg
`default_nettype wire

// ---- encoder_connector_pin_mux.sv ----
// Per-channel pin function multiplexer for the encoder feedback connector
//
// Functional notes
// - Amp-enable jumper on: drive amplifier enable on phase A pair; off: input.
// - Fault jumper on: take amplifier fault from phase B pair; else ignore.
// - Flag routing 1 with serial mode 0: drive step pulse and direction on flag and Hall lines.
// - Flag routing resets to 0; then flag and Hall lines are inputs.
// - Serial mode 1: place serial data, clock and strobe on shared pins.
// - Serial mode resets to 0; shared pins then serve flags or pulse outputs.
// - Strobe-off jumper frees the strobe pair for the index even in serial mode.
// - Decode select 0 or 4: phase A/B read as pulse and direction.
// - Quadrature decode uses other decode values, typically 3 or 7.
// - Index input serves as the channel's position capture flag.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module encoder_connector_pin_mux (
	input  wire logic                                        clk_i,
	input  wire logic                                        rst_i,
	input  wire logic                                        wb_cyc_i,
	input  wire logic                                        wb_stb_i,
	input  wire logic                                        wb_we_i,
	input  wire logic [pin_mux_pkg::ADDR_W-1:0]              wb_adr_i,
	input  wire logic [3:0]                                  wb_sel_i,
	input  wire logic [pin_mux_pkg::DATA_W-1:0]              wb_dat_i,
	output logic      [pin_mux_pkg::DATA_W-1:0]              wb_dat_o,
	output logic                                             wb_ack_o,
	input  wire pin_mux_pkg::pin_bits_t   [pin_mux_pkg::NUM_CH-1:0] pin_in_i,
	input  wire pin_mux_pkg::jumper_t     [pin_mux_pkg::NUM_CH-1:0] jumper_i,
	input  wire pin_mux_pkg::axis_drive_t [pin_mux_pkg::NUM_CH-1:0] axis_drive_i,
	output pin_mux_pkg::pin_bits_t        [pin_mux_pkg::NUM_CH-1:0] pin_out_o,
	output pin_mux_pkg::pin_bits_t        [pin_mux_pkg::NUM_CH-1:0] pin_oe_o,
	output pin_mux_pkg::axis_sense_t      [pin_mux_pkg::NUM_CH-1:0] axis_sense_o
);
	import pin_mux_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	pin_bits_t   [NUM_CH-1:0] pin_meta_q;
	pin_bits_t   [NUM_CH-1:0] pin_sync_q;
	jumper_t     [NUM_CH-1:0] jmp_meta_q;
	jumper_t     [NUM_CH-1:0] jmp_sync_q;
	chan_cfg_t                cfg_q [NUM_CH];
	pin_bits_t                out_d [NUM_CH];
	pin_bits_t                oe_d  [NUM_CH];
	axis_sense_t              sense_d [NUM_CH];
	logic        [DATA_W-1:0] stat_word [NUM_CH];
	logic                     req;
	logic                     wr_fire;
	logic                     ch_sel;
	logic                     bank_sel;
	logic        [DATA_W-1:0] rd_d;
	logic        [1:0]        settle_q;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	// Connector lines and jumpers are asynchronous; two flops before any use
	always_ff @(posedge clk_i) begin
		pin_meta_q <= pin_in_i;
		pin_sync_q <= pin_meta_q;
	end

	// Jumpers are static in practice but may be moved under power
	always_ff @(posedge clk_i) begin
		jmp_meta_q <= jumper_i;
		jmp_sync_q <= jmp_meta_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	// Address split: bank selects control or status, next bit the channel
	assign req      = wb_cyc_i & wb_stb_i;
	assign ch_sel   = wb_adr_i[CH_SEL_BIT];
	assign bank_sel = wb_adr_i[BANK_BIT];
	// Commit on the edge at which the master sees ack
	assign wr_fire  = req & wb_we_i & wb_ack_o & wb_sel_i[0] & (bank_sel == CTRL_BASE[BANK_BIT]);

	// One wait state, ack drops right after; every address answers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	// Read mux; status bank is read-only, writes to it are dropped
	always_comb begin
		rd_d = '0;
		if (bank_sel == STAT_BASE[BANK_BIT]) begin
			rd_d = stat_word[ch_sel];
		end else begin
			rd_d[ROUTE_BIT]                 = cfg_q[ch_sel].route;
			rd_d[SERIAL_BIT]                = cfg_q[ch_sel].serial;
			rd_d[DEC_LSB +: DEC_W]          = cfg_q[ch_sel].decode;
		end
	end

	// Read data captured as ack rises and held while it stands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req & ~wb_ack_o) begin
			wb_dat_o <= rd_d;
		end
	end

	// Settings registers, power-on values keep every shared line an input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int j = 0; j < NUM_CH; j++) begin
				cfg_q[j].route  <= ROUTE_RESET;
				cfg_q[j].serial <= SERIAL_RESET;
				cfg_q[j].decode <= DEC_RESET;
			end
		end else if (wr_fire) begin
			cfg_q[ch_sel].route  <= wb_dat_i[ROUTE_BIT];
			cfg_q[ch_sel].serial <= wb_dat_i[SERIAL_BIT];
			cfg_q[ch_sel].decode <= wb_dat_i[DEC_LSB +: DEC_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel multiplexing

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic serial_on;
		logic route_on;
		logic strobe_use;
		logic flags_in;
		logic pulse_mode;

		assign serial_on  = cfg_q[g].serial;
		assign route_on   = cfg_q[g].route & ~cfg_q[g].serial;
		// Strobe jumper wins over serial mode so the index can come in
		assign strobe_use = serial_on & ~jmp_sync_q[g].strobe_off;
		assign flags_in   = ~cfg_q[g].route & ~cfg_q[g].serial;
		assign pulse_mode = (cfg_q[g].decode == DEC_PULSE_LO) ||
				(cfg_q[g].decode == DEC_PULSE_HI);

		// Pin drive; serial mode outranks flag routing to avoid two drivers
		always_comb begin
			out_d[g] = '0;
			oe_d[g]  = '0;
			oe_d[g].a  = jmp_sync_q[g].amp_en;
			out_d[g].a = jmp_sync_q[g].amp_en & axis_drive_i[g].amp_enable;
			oe_d[g].c  = strobe_use;
			out_d[g].c = strobe_use & axis_drive_i[g].ser_strobe;
			if (serial_on) begin
				oe_d[g].w  = axis_drive_i[g].ser_data_oe;
				oe_d[g].t  = axis_drive_i[g].ser_data_oe;
				out_d[g].w = axis_drive_i[g].ser_data;
				out_d[g].t = ~axis_drive_i[g].ser_data;
				oe_d[g].u  = 1'b1;
				oe_d[g].v  = 1'b1;
				out_d[g].u = axis_drive_i[g].ser_clk;
				out_d[g].v = ~axis_drive_i[g].ser_clk;
			end else if (route_on) begin
				oe_d[g].w  = 1'b1;
				oe_d[g].t  = 1'b1;
				out_d[g].w = axis_drive_i[g].step_pulse;
				out_d[g].t = ~axis_drive_i[g].step_pulse;
				oe_d[g].u  = 1'b1;
				oe_d[g].v  = 1'b1;
				out_d[g].u = axis_drive_i[g].step_dir;
				out_d[g].v = ~axis_drive_i[g].step_dir;
			end
		end

		// Sensed signals back to the axis logic
		always_comb begin
			sense_d[g]             = '0;
			sense_d[g].quad_mode   = ~pulse_mode;
			sense_d[g].quad_a      = ~pulse_mode & pin_sync_q[g].a & ~jmp_sync_q[g].amp_en;
			sense_d[g].quad_b      = ~pulse_mode & pin_sync_q[g].b;
			sense_d[g].pulse_in    = pulse_mode & pin_sync_q[g].a & ~jmp_sync_q[g].amp_en;
			sense_d[g].dir_in      = pulse_mode & pin_sync_q[g].b;
			sense_d[g].fault       = jmp_sync_q[g].fault_en & pin_sync_q[g].b;
			sense_d[g].capture     = ~strobe_use & pin_sync_q[g].c;
			sense_d[g].gp_flag     = flags_in & pin_sync_q[g].t;
			sense_d[g].hall_u      = flags_in & pin_sync_q[g].u;
			sense_d[g].hall_v      = flags_in & pin_sync_q[g].v;
			sense_d[g].hall_w      = flags_in & pin_sync_q[g].w;
			sense_d[g].ser_data_in = serial_on & ~axis_drive_i[g].ser_data_oe & pin_sync_q[g].w;
		end

		// Status word: modes in effect plus the raw synchronised lines
		always_comb begin
			stat_word[g]                              = '0;
			stat_word[g][ST_QUAD_BIT]                 = ~pulse_mode;
			stat_word[g][ST_STROBE_BIT]               = strobe_use;
			stat_word[g][ST_AMP_BIT]                  = jmp_sync_q[g].amp_en;
			stat_word[g][ST_FAULT_BIT]                = jmp_sync_q[g].fault_en;
			stat_word[g][ST_PINS_LSB +: $bits(pin_bits_t)] = pin_sync_q[g];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output registers

	// All outputs come from flops; reset leaves every line undriven
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_out_o    <= '0;
			pin_oe_o     <= '0;
			axis_sense_o <= '0;
		end else begin
			for (int j = 0; j < NUM_CH; j++) begin
				pin_out_o[j]    <= out_d[j];
				pin_oe_o[j]     <= oe_d[j];
				axis_sense_o[j] <= sense_d[j];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	// Two clean cycles after reset before $past is meaningful
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_q <= '0;
		end else begin
			settle_q <= {settle_q[0], 1'b1};
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || !settle_q[1]);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");

	// Every request is answered after exactly one wait state
	a_ack_answer: assert property ((req && !wb_ack_o) |=> wb_ack_o)
		else $error("bus request not answered in one wait state");
	a_ack_cause: assert property (wb_ack_o |-> $past(req))
		else $error("bus ack without a request");

	// Read data holds as ack drops and reports the addressed channel
	a_rdata_hold: assert property (wb_ack_o |=> $stable(wb_dat_o))
		else $error("read data moved as ack dropped");
	a_rdata_ctrl: assert property (
		(req && !wb_ack_o && !wb_we_i && bank_sel == CTRL_BASE[BANK_BIT]) |=>
		wb_dat_o[DEC_LSB +: DEC_W] == $past(cfg_q[ch_sel].decode) &&
		wb_dat_o[SERIAL_BIT] == $past(cfg_q[ch_sel].serial))
		else $error("read data not from the addressed channel");

	for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
		a_amp_drive: assert property (
			pin_oe_o[g].a == $past(jmp_sync_q[g].amp_en) &&
			(!pin_oe_o[g].a || pin_out_o[g].a == $past(axis_drive_i[g].amp_enable)))
			else $error("amp enable drive does not follow its jumper");
		a_fault_gate: assert property (
			!$past(jmp_sync_q[g].fault_en) |-> !axis_sense_o[g].fault && !pin_oe_o[g].b)
			else $error("fault taken with its jumper off");
		a_route_step: assert property (
			($past(cfg_q[g].route) && !$past(cfg_q[g].serial)) |->
			pin_oe_o[g].u && pin_oe_o[g].w && pin_out_o[g].u != pin_out_o[g].v &&
			pin_out_o[g].w == $past(axis_drive_i[g].step_pulse))
			else $error("step outputs missing while routed");
		a_flag_input: assert property (
			(!$past(cfg_q[g].route) && !$past(cfg_q[g].serial)) |->
			!(pin_oe_o[g].t | pin_oe_o[g].u | pin_oe_o[g].v | pin_oe_o[g].w) &&
			axis_sense_o[g].hall_u == $past(pin_sync_q[g].u))
			else $error("flag lines not inputs");
		a_serial_clock: assert property (
			$past(cfg_q[g].serial) |-> pin_oe_o[g].u &&
			pin_out_o[g].u == $past(axis_drive_i[g].ser_clk))
			else $error("serial clock not driven in serial mode");
		a_serial_off: assert property (
			!$past(cfg_q[g].serial) |-> !pin_oe_o[g].c && !axis_sense_o[g].ser_data_in)
			else $error("serial pins active with serial mode off");
		a_strobe_free: assert property (
			$past(jmp_sync_q[g].strobe_off) |->
			!pin_oe_o[g].c && axis_sense_o[g].capture == $past(pin_sync_q[g].c))
			else $error("strobe pair not freed for index");
		a_pulse_decode: assert property (
			($past(cfg_q[g].decode) == DEC_PULSE_LO || $past(cfg_q[g].decode) == DEC_PULSE_HI)
			|-> !axis_sense_o[g].quad_mode && !axis_sense_o[g].quad_a &&
			axis_sense_o[g].dir_in == $past(pin_sync_q[g].b))
			else $error("pulse decode not applied");
		a_quad_decode: assert property (
			($past(cfg_q[g].decode) == DEC_QUAD_LO || $past(cfg_q[g].decode) == DEC_QUAD_HI)
			|-> axis_sense_o[g].quad_mode &&
			axis_sense_o[g].quad_b == $past(pin_sync_q[g].b))
			else $error("quadrature decode not applied");

		// Refused writes and writes to the other channel leave settings alone
		a_status_ro: assert property (
			(req && wb_we_i && (bank_sel == STAT_BASE[BANK_BIT] || !wb_sel_i[0])) |=>
			$stable(cfg_q[g]))
			else $error("settings changed by a refused write");
		a_chan_isolate: assert property (
			(wr_fire && ch_sel != 1'(g)) |=> $stable(cfg_q[g]))
			else $error("write reached the wrong channel");
		a_write_lands: assert property (
			(wr_fire && ch_sel == 1'(g)) |=>
			cfg_q[g].decode == $past(wb_dat_i[DEC_LSB +: DEC_W]) &&
			cfg_q[g].serial == $past(wb_dat_i[SERIAL_BIT]) &&
			cfg_q[g].route == $past(wb_dat_i[ROUTE_BIT]))
			else $error("write did not land in its channel");

		// Serial lines: data follows its own enable, strobe unless jumpered off
		a_serial_data: assert property (
			$past(cfg_q[g].serial) |->
			pin_oe_o[g].w == $past(axis_drive_i[g].ser_data_oe) &&
			pin_out_o[g].w == $past(axis_drive_i[g].ser_data))
			else $error("serial data not on its pair");
		a_strobe_drive: assert property (
			($past(cfg_q[g].serial) && !$past(jmp_sync_q[g].strobe_off)) |->
			pin_oe_o[g].c && pin_out_o[g].c == $past(axis_drive_i[g].ser_strobe))
			else $error("serial strobe missing with its jumper off");
		a_index_capture: assert property (
			(!$past(cfg_q[g].serial) || $past(jmp_sync_q[g].strobe_off)) |->
			axis_sense_o[g].capture == $past(pin_sync_q[g].c))
			else $error("index not passed to capture");

		// Input senses gated by their selecting settings and jumpers
		a_pulse_lines: assert property (
			($past(cfg_q[g].decode) == DEC_PULSE_LO || $past(cfg_q[g].decode) == DEC_PULSE_HI)
			|-> axis_sense_o[g].pulse_in ==
			($past(pin_sync_q[g].a) && !$past(jmp_sync_q[g].amp_en)))
			else $error("pulse input not taken from phase A");
		a_amp_sense: assert property (
			$past(jmp_sync_q[g].amp_en) |-> !axis_sense_o[g].quad_a && !axis_sense_o[g].pulse_in)
			else $error("amp enable pair read as encoder input");
		a_fault_take: assert property (
			$past(jmp_sync_q[g].fault_en) |-> axis_sense_o[g].fault == $past(pin_sync_q[g].b))
			else $error("fault not taken from phase B");
		a_flags_masked: assert property (
			($past(cfg_q[g].route) || $past(cfg_q[g].serial)) |->
			!(axis_sense_o[g].gp_flag | axis_sense_o[g].hall_u |
			axis_sense_o[g].hall_v | axis_sense_o[g].hall_w))
			else $error("flag senses live while lines are in use");

		// No shared line driven without a setting asking, complements driven in pairs
		a_pin_quiet: assert property (
			!pin_oe_o[g].b &&
			(!(pin_oe_o[g].t | pin_oe_o[g].u | pin_oe_o[g].v | pin_oe_o[g].w) ||
			$past(cfg_q[g].route) || $past(cfg_q[g].serial)))
			else $error("shared line driven with no setting asking for it");
		a_pair_together: assert property (
			pin_oe_o[g].t == pin_oe_o[g].w && pin_oe_o[g].u == pin_oe_o[g].v)
			else $error("complement line driven alone");
	end

endmodule : encoder_connector_pin_mux
`default_nettype wire

// ---- feedback_partner.sv ----
// Behavioural model of the encoders, Hall sensors and stepper drive on the connector
`timescale 1ns/1ns
`default_nettype none
module feedback_partner (
	input  wire pin_mux_pkg::pin_bits_t [pin_mux_pkg::NUM_CH-1:0] src_i,
	input  wire pin_mux_pkg::pin_bits_t [pin_mux_pkg::NUM_CH-1:0] drv_i,
	input  wire pin_mux_pkg::pin_bits_t [pin_mux_pkg::NUM_CH-1:0] oe_i,
	output pin_mux_pkg::pin_bits_t      [pin_mux_pkg::NUM_CH-1:0] line_o
);
	import pin_mux_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Line level: block wins where it drives, sensor levels elsewhere
	// Sensors always drive, so a line released by the block never floats
	always_comb begin
		line_o = (oe_i & drv_i) | (~oe_i & src_i);
	end
endmodule : feedback_partner
`default_nettype wire

// ---- encoder_connector_pin_mux_tb.sv ----
// Self-checking bench for the encoder connector pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module encoder_connector_pin_mux_tb;
	import pin_mux_pkg::*;
	logic                   clk, rst, cyc, stb, we, ack;
	logic [3:0]             sel;
	logic [ADDR_W-1:0]      adr;
	logic [DATA_W-1:0]      wdat, dat, rdat;
	pin_bits_t [NUM_CH-1:0] src, lvl, pout, poe;
	jumper_t [NUM_CH-1:0]   jmp;
	axis_drive_t [NUM_CH-1:0] axd;
	axis_sense_t [NUM_CH-1:0] sense;
	int                     fail_count, check_count, d;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, block and connector model
	always #25 clk = ~clk;

	encoder_connector_pin_mux DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat),
		.wb_ack_o(ack), .pin_in_i(lvl), .jumper_i(jmp), .axis_drive_i(axd),
		.pin_out_o(pout), .pin_oe_o(poe), .axis_sense_o(sense));

	feedback_partner partner (.src_i(src), .drv_i(pout), .oe_i(poe), .line_o(lvl));

	////////////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// Classic single Wishbone cycle; waits for ack under a bound
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v,
		input logic [3:0] s = 4'hf);
		int n;
		@(posedge clk);
		cyc  <= 1'b1;
		sel  <= s;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= v;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		if (n == 20) begin
			fail_count++;
			$display("ERROR %0t: bus ack timeout", $time);
			tally_and_finish;
		end
		rdat = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		check(rdat, exp);
	endtask : rd

	// Covers the two-flop sync plus output flop with margin
	task automatic settle;
		repeat (5) @(posedge clk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'hf;
		adr = '0;
		wdat = '0;
		src = '0;
		jmp = '0;
		axd = '0;
		fail_count = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		check(32'(poe), 32'h0000_0000);
		rd(4'h0, 32'h0000_0030);
		rd(4'h4, 32'h0000_0030);
		// Status bank is read-only
		wb(1'b1, 4'h8, 32'hffff_ffff);
		rd(4'h0, 32'h0000_0030);
		// Writes without byte lane 0 are acknowledged and dropped
		wb(1'b1, 4'h4, 32'h0000_0033, 4'he);
		rd(4'h4, 32'h0000_0030);
		// Free lines feed flag and Hall senses
		src[0] <= 7'b000_1011;
		settle;
		check(32'({sense[0].gp_flag, sense[0].hall_u, sense[0].hall_v, sense[0].hall_w}),
			32'h0000_000b);
		// Step pulse and direction onto the flag lines
		axd[0].step_pulse <= 1'b1;
		wb(1'b1, 4'h0, 32'h0000_0031);
		settle;
		check(32'(poe[0]), 32'h0000_000f);
		check(32'(pout[0]), 32'h0000_0003);
		// Serial mode wins over step routing
		axd[0].ser_clk <= 1'b1;
		axd[0].ser_strobe <= 1'b1;
		axd[0].ser_data_oe <= 1'b1;
		wb(1'b1, 4'h0, 32'h0000_0033);
		settle;
		check(32'(poe[0]), 32'h0000_001f);
		check(32'(pout[0]), 32'h0000_001c);
		rd(4'h8, 32'h0000_1c03);
		// Strobe pair handed back to the index
		jmp[0].strobe_off <= 1'b1;
		axd[0].ser_data_oe <= 1'b0;
		src[0].c <= 1'b1;
		src[0].w <= 1'b1;
		settle;
		check(32'(poe[0]), 32'h0000_0006);
		check(32'(sense[0].capture), 32'h0000_0001);
		check(32'(sense[0].ser_data_in), 32'h0000_0001);
		wb(1'b1, 4'h0, 32'h0000_0030);
		settle;
		check(32'(poe), 32'h0000_0000);
		// Amplifier enable and fault on the second channel
		jmp[1].amp_en <= 1'b1;
		jmp[1].fault_en <= 1'b1;
		axd[1].amp_enable <= 1'b1;
		src[1].b <= 1'b1;
		settle;
		check(32'(poe[1]), 32'h0000_0040);
		check(32'({pout[1].a, sense[1].quad_a, sense[1].fault}), 32'h0000_0005);
		rd(4'hc, 32'h0000_600d);
		jmp[1].fault_en <= 1'b0;
		jmp[1].amp_en <= 1'b0;
		src[1].a <= 1'b1;
		settle;
		check(32'({poe[1].a, sense[1].fault}), 32'h0000_0000);
		// Every decode selection on the second channel
		for (d = 0; d < 8; d++) begin
			wb(1'b1, 4'h4, {25'h0, 3'(d), 4'h0});
			settle;
			check(32'({sense[1].quad_mode, sense[1].pulse_in, sense[1].quad_a,
				sense[1].dir_in, sense[1].quad_b}),
				(d == 0 || d == 4) ? 32'h0000_000a : 32'h0000_0015);
		end
		rd(4'h4, 32'h0000_0070);
		rd(4'h0, 32'h0000_0030);
		// Serial mode with the strobe jumper, then a reset in mid-run
		wb(1'b1, 4'h0, 32'h0000_0032);
		settle;
		check(32'(poe[0]), 32'h0000_0006);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		check(32'(poe), 32'h0000_0000);
		rd(4'h0, 32'h0000_0030);
		rd(4'h4, 32'h0000_0030);
		tally_and_finish;
	end
endmodule : encoder_connector_pin_mux_tb
`default_nettype wire
